/* logic/bps_status.sv */
// Functional notes
// - Bits 31:22 read back as zero
// - Set bit 21 on delayed upstream split request
// - Set bit 20 on split completion overrun
// - Set bit 19 on unexpected own-ID completion
// - Set bit 18 on discarded primary completion
// - Bit 17 always reads one
// - Bit 16 from strap low at reset release
// - Bits 15:8 mirror primary bus number input, no reset of their own
// - Completer ID formed from bus, device, function
// - Same ID used in mixed PCI/PCI-X mode
// - Device number loaded from AD[15:11] on writes
// - Addressed: address strobe, IDSEL, type 0, function
// - Function number read-only, resets to zero
// - Upstream limit 16 bits, resets to capacity
`timescale 1ns/100ps
module bps_status
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// Configuration access, one-cycle address phase then data phase
	input  wire logic        cfg_addr_valid_i,
	input  wire logic [3:0]  cfg_cmd_i,
	input  wire logic        cfg_idsel_i,
	input  wire logic [31:0] cfg_ad_i,
	input  wire logic        cfg_data_valid_i,
	input  wire logic [3:0]  cfg_byte_en_n_i,
	input  wire logic [31:0] cfg_wdata_i,
	output logic      [31:0] cfg_rdata_o,
	output logic             cfg_rdata_valid_o,
	// Primary bus number from the type 1 header
	input  wire logic [7:0]  primary_bus_number_i,
	input  wire logic        primary_wide_request_strap_n_i,
	// Split-transaction event pulses from the bridge core
	input  wire logic        split_req_delayed_i,
	input  wire logic        split_cpl_overrun_i,
	input  wire logic        unexpected_split_cpl_i,
	input  wire logic        split_cpl_discarded_i,
	output logic      [15:0] completer_id_o,
	output logic      [15:0] upstream_split_limit_o,
	output logic             primary_wide_ad_o
);
	import bps_pkg::*;

	// Byte-lane enable for a write, active-low C/BE.
	// Lanes not enabled leave their bytes untouched.
	function automatic logic lane_on(input logic [3:0] be_n, input int lane);
		lane_on = ~be_n[lane];
	endfunction

	typedef enum logic [1:0] {BPS_IDLE, BPS_WRITE, BPS_READ} bps_phase_t;

	bps_phase_t  phase_q, phase_d;
	logic [7:0]  reg_off_q, reg_off_d;
	logic [3:0]  flags_q, flags_d;
	logic [4:0]  dev_q, dev_d;
	logic [15:0] limit_q, limit_d;
	logic        wide_q, wide_d;
	logic        in_reset_q;
	logic [31:0] rdata_q, rdata_d;
	logic        rvalid_q, rvalid_d;
	logic        addressed;
	logic [31:0] status_word;
	logic [3:0]  events;
	logic [3:0]  clr_mask;
	// Data-phase strobes and the flag loop index
	logic        data_wr;
	logic        data_rd;
	genvar       g;

	// Address-phase decode of a type 0 access to this function.
	// Any other function number or a missing IDSEL is another target.
	always_comb
	begin
		addressed = cfg_addr_valid_i && cfg_idsel_i && (cfg_ad_i[1:0] == BPS_TYPE0)
			&& (cfg_ad_i[10:8] == BPS_FUNC_RESET);
	end

	// Read view of the status word.
	// Reserved upper bits start at zero and are never written.
	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[BPS_BIT_REQ_DELAYED -: 4] = flags_q;
		status_word[BPS_BIT_133_CAPABLE] = 1'b1;
		status_word[BPS_BIT_WIDE_DEVICE] = wide_q;
		status_word[BPS_BUS_LSB +: 8] = primary_bus_number_i;
		status_word[BPS_DEV_LSB +: 5] = dev_q;
		status_word[BPS_FUNC_LSB +: 3] = BPS_FUNC_RESET;
	end

	// Events in flag order 21..18; each is a one-cycle pulse from the bridge core
	assign events = {
		split_req_delayed_i,
		split_cpl_overrun_i,
		unexpected_split_cpl_i,
		split_cpl_discarded_i
	};

	// Command decode, shared by the address-phase and device-number logic
	function automatic logic is_cfg_write(input logic [3:0] cmd);
		is_cfg_write = (cmd == BPS_CMD_CFG_WRITE);
	endfunction

	function automatic logic is_cfg_read(input logic [3:0] cmd);
		is_cfg_read = (cmd == BPS_CMD_CFG_READ);
	endfunction

	// Offset match on the dword-aligned register index.
	// Shared by every decode so the flag, limit and read paths agree.
	function automatic logic at_offset(input logic [7:0] off, input logic [7:0] target);
		at_offset = (off == target);
	endfunction

	// Data-phase strobes for the access in flight.
	// Only one of them can be high, as the phase holds one kind of access.
	always_comb
	begin
		data_wr = (phase_q == BPS_WRITE) && cfg_data_valid_i;
		data_rd = (phase_q == BPS_READ) && cfg_data_valid_i;
	end

	// Access tracking. The address phase latches the register index and the kind of
	// access; the state then waits for the data strobe, however late it comes.
	// A new address strobe during a pending data phase replaces the register index but not the
	// kind of access, so a host must finish one access before starting the next.
	always_comb
	begin
		phase_d   = BPS_IDLE;
		reg_off_d = reg_off_q;
		if (addressed)
		begin
			reg_off_d = {cfg_ad_i[7:2], 2'b00};
			if (is_cfg_write(cfg_cmd_i))
				phase_d = BPS_WRITE;
			else if (is_cfg_read(cfg_cmd_i))
				phase_d = BPS_READ;
		end
		case (phase_q)
			BPS_WRITE, BPS_READ:
			begin
				if (!cfg_data_valid_i)
					phase_d = phase_q;
			end
			BPS_IDLE:
			begin
			end
			default:
				phase_d = BPS_IDLE;
		endcase
	end

	// Access registers; an unused phase code
	// falls back to idle on the next clock
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			phase_q   <= BPS_IDLE;
			reg_off_q <= 8'h00;
		end
		else
		begin
			phase_q   <= phase_d;
			reg_off_q <= reg_off_d;
		end
	end

	// Clear mask from a write-one to the status flags.
	// Writes without byte lane 2 leave the flags alone.
	always_comb
	begin
		clr_mask = 4'h0;
		if (data_wr && at_offset(reg_off_q, BPS_STATUS_OFFSET) && lane_on(cfg_byte_en_n_i, 2))
			clr_mask = cfg_wdata_i[BPS_BIT_REQ_DELAYED -: 4];
	end

	// One sticky flag per event, bit 0 being the discard flag at status bit 18.
	// A set arriving with a clear wins, so software can never wipe out an event
	// that lands in the same cycle as its write-one-to-clear.
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_flag
			assign flags_d[g] = events[g] | (flags_q[g] & ~clr_mask[g]);
		end
	endgenerate

	// Flag registers; all four
	// come out of reset clear
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			flags_q <= 4'h0;
		else
			flags_q <= flags_d;
	end

	// Device number follows every addressing write, whatever register it targets.
	// Reads never change it, so a probe by software leaves the ID intact.
	always_comb
	begin
		dev_d = dev_q;
		if (addressed && is_cfg_write(cfg_cmd_i))
			dev_d = cfg_ad_i[15:11];
	end

	// Device number register; the all-ones reset value
	// marks it as not yet assigned by the system
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			dev_q <= BPS_DEV_RESET;
		else
			dev_q <= dev_d;
	end

	// Upstream limit; software is trusted to keep it at or above the capacity.
	// No clamp is applied, which keeps the write path a plain byte merge.
	always_comb
	begin
		limit_d = limit_q;
		if (data_wr && at_offset(reg_off_q, BPS_UP_SPLIT_OFFSET))
		begin
			if (lane_on(cfg_byte_en_n_i, 2))
				limit_d[7:0] = cfg_wdata_i[23:16];
			if (lane_on(cfg_byte_en_n_i, 3))
				limit_d[15:8] = cfg_wdata_i[31:24];
		end
	end

	// Limit register; it restarts at the capacity
	// so a fresh bridge never overcommits
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			limit_q <= BPS_SPLIT_CAPACITY;
		else
			limit_q <= limit_d;
	end

	// Read data; unmapped offsets answer zero rather than stale data.
	// The word is captured at the data-phase edge and shown one clock later.
	always_comb
	begin
		rdata_d  = rdata_q;
		rvalid_d = data_rd;
		if (data_rd)
		begin
			if (at_offset(reg_off_q, BPS_STATUS_OFFSET))
				rdata_d = status_word;
			else if (at_offset(reg_off_q, BPS_UP_SPLIT_OFFSET))
				rdata_d = {limit_q, BPS_SPLIT_CAPACITY};
			else
				rdata_d = 32'h0000_0000;
		end
	end

	// Read registers; data holds until the next read
	// so a slow host can still pick it up
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			rdata_q  <= 32'h0000_0000;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// Strap is sampled on the first clock after reset release, then frozen.
	// A strap that moves later has no effect until the next reset.
	always_comb
	begin
		wide_d = wide_q;
		if (in_reset_q)
			wide_d = ~primary_wide_request_strap_n_i;
	end

	// Strap registers; reset is synchronous
	// so the reset branch holds constants only
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			wide_q     <= 1'b0;
			in_reset_q <= 1'b1;
		end
		else
		begin
			wide_q     <= wide_d;
			in_reset_q <= 1'b0;
		end
	end

	// Completer ID serves both PCI-X and mixed-mode operation.
	// The bus part is live, so a header update shows at once.
	assign completer_id_o         = {primary_bus_number_i, dev_q, BPS_FUNC_RESET};
	assign upstream_split_limit_o = limit_q;
	assign primary_wide_ad_o      = wide_q;
	assign cfg_rdata_o            = rdata_q;
	assign cfg_rdata_valid_o      = rvalid_q;
endmodule

/* pkg/bps_pkg.sv */
package bps_pkg;
	// Register offsets (byte addresses in configuration space)
	localparam logic [7:0]  BPS_STATUS_OFFSET   = 8'h84;
	localparam logic [7:0]  BPS_UP_SPLIT_OFFSET = 8'h88;
	// Status field positions
	localparam int          BPS_BIT_REQ_DELAYED = 21;
	localparam int          BPS_BIT_CPL_OVERRUN = 20;
	localparam int          BPS_BIT_UNEXP_CPL   = 19;
	localparam int          BPS_BIT_CPL_DISCARD = 18;
	localparam int          BPS_BIT_133_CAPABLE = 17;
	localparam int          BPS_BIT_WIDE_DEVICE = 16;
	localparam int          BPS_BUS_LSB         = 8;
	localparam int          BPS_DEV_LSB         = 3;
	localparam int          BPS_FUNC_LSB        = 0;
	localparam int          BPS_LIMIT_LSB       = 16;
	// Reset values
	localparam logic [7:0]  BPS_BUS_RESET       = 8'hff;
	localparam logic [4:0]  BPS_DEV_RESET       = 5'h1f;
	localparam logic [2:0]  BPS_FUNC_RESET      = 3'h0;
	localparam logic [15:0] BPS_SPLIT_CAPACITY  = 16'h0020;
	// Configuration command codes on C/BE[3:0]
	localparam logic [3:0]  BPS_CMD_CFG_READ    = 4'ha;
	localparam logic [3:0]  BPS_CMD_CFG_WRITE   = 4'hb;
	localparam logic [1:0]  BPS_TYPE0           = 2'h0;
endpackage

/* testbench/bps_status_assertions.sv */
`timescale 1ns/100ps
module bps_status_chk
	import bps_pkg::*;
(
	input logic        clk_i,
	input logic        reset_i,
	input logic        cfg_addr_valid_i,
	input logic [3:0]  cfg_cmd_i,
	input logic        cfg_idsel_i,
	input logic [31:0] cfg_ad_i,
	input logic        cfg_rdata_valid_o,
	input logic [7:0]  primary_bus_number_i,
	input logic        primary_wide_request_strap_n_i,
	input logic [15:0] completer_id_o,
	input logic [15:0] upstream_split_limit_o,
	input logic        primary_wide_ad_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Addressing write; only function zero answers
	wire w = cfg_addr_valid_i && cfg_idsel_i && cfg_cmd_i == 4'hb && cfg_ad_i[1:0] == 2'h0 && cfg_ad_i[10:8] == 3'h0;
	dev_load_a: assert property (w |=> completer_id_o[7:3] == $past(cfg_ad_i[15:11]))
		else $error("device number not loaded");
	dev_keep_a: assert property (!w |=> $stable(completer_id_o[7:3]))
		else $error("device number changed");
	dev_reset_a: assert property ($fell(reset_i) |-> completer_id_o[7:3] == 5'h1f)
		else $error("device reset value");
	id_func_a: assert property (completer_id_o[2:0] == 3'h0)
		else $error("function number");
	id_bus_a: assert property (completer_id_o[15:8] == primary_bus_number_i)
		else $error("completer bus");
	lim_reset_a: assert property ($fell(reset_i) |-> upstream_split_limit_o == 16'h0020)
		else $error("limit reset value");
	wide_cap_a: assert property ($fell(reset_i) |=> primary_wide_ad_o == !$past(primary_wide_request_strap_n_i))
		else $error("wide path");
	rv_pulse_a: assert property (cfg_rdata_valid_o |=> !cfg_rdata_valid_o)
		else $error("read valid too long");
endmodule
bind bps_status bps_status_chk i_chk (.*);

/* testbench/bps_host.sv */
`timescale 1ns/100ps
module bps_host(
	input logic         clk_i,
	output logic        av_o = 0,
	output logic        dv_o = 0,
	output logic [3:0]  cmd_o = 0,
	output logic [31:0] ad_o = 0,
	output logic [31:0] wd_o = 0
);
	// Address then data phase; released lines invert so stale values never match
	task automatic xfer(input logic [3:0] c, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{av_o, cmd_o, ad_o} <= {1'b1, c, a};
		@(posedge clk_i);
		{av_o, dv_o, cmd_o, ad_o, wd_o} <= {2'b01, ~c, ~a, d};
		@(posedge clk_i);
		{dv_o, wd_o} <= {1'b0, ~d};
	endtask
endmodule

/* testbench/tb_bps_status.sv */
`timescale 1ns/100ps
module tb_bps_status;
	logic        clk_i = 0, reset_i = 1, strap_n, av, dv, rv, wide, idsel = 1;
	logic [3:0]  cmd, ev = 0;
	logic [7:0]  bus = 0;
	logic [15:0] cid, lim;
	logic [31:0] ad, wd, rd_d, r;
	int          n_fail, total_checks, cyc, fl, dev = 31, seed = 32'hb657;
	bps_host i_bps_host(.clk_i, .av_o(av), .dv_o(dv), .cmd_o(cmd), .ad_o(ad), .wd_o(wd));
	bps_status i_bps_status(.clk_i, .reset_i, .cfg_addr_valid_i(av), .cfg_cmd_i(cmd), .cfg_idsel_i(idsel),
		.cfg_ad_i(ad), .cfg_data_valid_i(dv), .cfg_byte_en_n_i(4'h0), .cfg_wdata_i(wd), .cfg_rdata_o(rd_d),
		.cfg_rdata_valid_o(rv), .primary_bus_number_i(bus), .primary_wide_request_strap_n_i(strap_n),
		.split_req_delayed_i(ev[3]), .split_cpl_overrun_i(ev[2]), .unexpected_split_cpl_i(ev[1]),
		.split_cpl_discarded_i(ev[0]), .completer_id_o(cid), .upstream_split_limit_o(lim), .primary_wide_ad_o(wide));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function automatic logic [31:0] st();
		return {10'h0, fl[3:0], 1'b1, !strap_n, bus, dev[4:0], 3'h0};
	endfunction
	// Read data lands a cycle after the data phase, so wait past it
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		i_bps_host.xfer(4'ha, a, 32'h0);
		@(negedge clk_i);
		chk("read valid", rv, 1);
		@(negedge clk_i);
		chk("read", rd_d, e);
		chk("read valid off", rv, 0);
	endtask
	always #25 clk_i = ~clk_i;
	// Hang guard; a full run needs some 135 cycles
	always @(posedge clk_i)
		if (++cyc > 3000)
		begin
			n_fail++;
			wrap_up();
		end
	initial
	begin
		r = $random(seed);
		strap_n = r[0];
		repeat (20) @(posedge clk_i);
		reset_i <= 0;
		repeat (3) @(posedge clk_i);
		chk("limit", lim, 32'h20);
		chk("wide", wide, !strap_n);
		repeat (8)
		begin
			rd(32'h84, st());
			chk("id", cid, {bus, dev[4:0], 3'h0});
			r = $random(seed);
			@(posedge clk_i);
			{ev, bus} <= {r[3:0], r[31:24]};
			@(posedge clk_i);
			ev <= 0;
			fl |= r[3:0];
			i_bps_host.xfer(4'hb, {r[15:11], 2'h0, r[8], 8'h84}, {8'h0, r[23:16], 16'h0});
			dev = r[8] ? dev : r[15:11];
			fl = r[8] ? fl : fl & ~r[21:18];
		end
		rd(32'h84, st());
		// Mid-run reset with the strap flipped; flags, device number and limit return to reset values, wide follows the new strap
		@(posedge clk_i);
		reset_i <= 1;
		strap_n <= ~strap_n;
		repeat (2) @(posedge clk_i);
		reset_i <= 0;
		fl = 0;
		dev = 31;
		repeat (3) @(posedge clk_i);
		chk("wide", wide, !strap_n);
		chk("limit", lim, 32'h20);
		rd(32'h84, st());
		// Event and clear land on the same edge: the set must win
		fork
			i_bps_host.xfer(4'hb, 32'h84, 32'h003c_0000);
			begin
				repeat (2) @(posedge clk_i);
				ev <= 4'h8;
				@(posedge clk_i);
				ev <= 0;
			end
		join
		fl = 8;
		dev = 0;
		rd(32'h84, st());
		// Write without IDSEL must not touch device number or flags
		@(posedge clk_i);
		idsel <= 0;
		i_bps_host.xfer(4'hb, 32'h0000_f884, 32'h003c_0000);
		idsel <= 1;
		rd(32'h84, st());
		i_bps_host.xfer(4'hb, 32'h88, r);
		dev = 0;
		rd(32'h88, {r[31:16], 16'h20});
		chk("limit", lim, r[31:16]);
		chk("id", cid, {bus, dev[4:0], 3'h0});
		rd(32'h8c, 0);
		wrap_up();
	end
endmodule
